// ### design/runtime_settings_cfg.svh
// Purpose: constants for the run-time settings write decoder
// Assumes: 64-byte command report, bytes delivered one per cycle
// Notes: offsets are byte indices within the report
// Contract
// - reference byte bit 7 set loads bits 2-0 as ADC reference selection
// - level field 11 high, 10 middle, 01 low, 00 reference module off
// - source bit 1 selects internal reference module, 0 selects supply
// - interrupt setup changes only when its bit 7 is one
// - bit 4 set loads rising-edge enable from bit 3
// - bit 2 set loads falling-edge enable from bit 1
// - bit 0 set clears detection flag, else flag kept
// - reconfiguration bit 7 set loads pin zero settings byte
// - pin zero as gpio output drives its output value bit
// - direction bit one input, zero output, only in gpio operation
// - designation 000 gpio, 001 suspend, 010 receive activity, others don't care
// - settings volatile only, lost at reset
`ifndef RUNTIME_SETTINGS_CFG_SVH
`define RUNTIME_SETTINGS_CFG_SVH
`define RPT_LEN          64
`define IDX_ADC_REF      6'h05
`define IDX_INT_SETUP    6'h06
`define IDX_PIN_ALTER    6'h07
`define IDX_PIN_ZERO     6'h08
`define BIT_LOAD         7
`define BIT_POS_MOD      4
`define BIT_POS_VAL      3
`define BIT_NEG_MOD      2
`define BIT_NEG_VAL      1
`define BIT_FLAG_CLR     0
`define BIT_OUT_VAL      4
`define BIT_DIR          3
`define REG_STATUS       4'h0
`define REG_MASK         4'h1
`define REG_SETTINGS     4'h2
`define ST_DONE          0
`define ST_DETECT        1
`define ADC_REF_RST      3'h0
`define PIN_ZERO_RST     8'h08
`define FLD_ADC          0
`define FLD_INT          1
`define FLD_ALTER        2
`define FLD_PIN          3
`define FLD_COUNT        4
`define ADC_LVL_HI       2
`define ADC_LVL_LO       1
`define ADC_SRC          0
`define DES_HI           2
`define DES_LO           0
`endif

// ### design/runtime_settings_pkg.sv
// Purpose: types for the run-time settings write decoder
// Assumes: nothing beyond the header
// Notes: none
package runtime_settings_pkg;
    typedef enum logic [1:0] {LVL_OFF, LVL_LOW, LVL_MID, LVL_HIGH} ref_level_t;
    typedef enum logic [2:0] {
        DES_GPIO, DES_SUSPEND, DES_RX_ACT, DES_R3, DES_R4, DES_R5, DES_R6, DES_R7
    } pin_des_t;
    typedef struct packed {
        logic [7:0] data;
        logic [5:0] index;
        logic       valid;
        logic       last;
    } rpt_byte_t;
    typedef struct packed {
        ref_level_t level;
        logic       use_module;
    } adc_ref_t;
endpackage : runtime_settings_pkg

// ### design/runtime_settings_write_decoder.sv
// Purpose: applies a set-run-time-settings report to volatile configuration
// Assumes: report bytes arrive in order with index; last marks byte 63
// Notes: fields are staged and applied together when the report ends
`timescale 1ns/1ps
`include "runtime_settings_cfg.svh"

module runtime_settings_write_decoder #(
    parameter int unsigned RPT_BYTES = `RPT_LEN
) (
    input  wire logic                            sys_clk,
    input  wire logic                            rst_n,
    input  wire runtime_settings_pkg::rpt_byte_t rpt_in,
    input  wire logic                            abort,
    input  wire logic                            int_in,
    input  wire logic                            suspend_state,
    input  wire logic                            rx_activity,
    input  wire logic [3:0]                      reg_addr,
    input  wire logic [7:0]                      reg_wdata,
    input  wire logic                            reg_wr,
    input  wire logic                            reg_rd,
    output logic [7:0]                           reg_rdata,
    output logic                                 irq,
    output runtime_settings_pkg::ref_level_t     ref_level,
    output logic                                 ref_module_on,
    output logic                                 ref_use_module,
    output logic                                 pin_out,
    output logic                                 pin_oe_n,
    output runtime_settings_pkg::pin_des_t       pin_mode,
    output logic                                 detect_flag
);

    ////////////////////////////////////////////////////////////////////////
    // staging: captured while the report streams in
    logic [7:0] stage_q [`FLD_COUNT];
    logic [7:0] adc_byte_q;
    logic [7:0] int_byte_q;
    logic [7:0] alter_byte_q;
    logic [7:0] pin_byte_q;
    logic       commit;
    logic       last_hit;

    // the index must reach the final byte, which must lie past every staged field
    if (RPT_BYTES > (1 << $bits(rpt_in.index)) || RPT_BYTES <= `IDX_PIN_ZERO + 1) begin : g_len_chk
        $error("report length out of range for the staged fields");
    end

    function automatic logic hit(input logic [5:0] idx, input logic [5:0] want);
        hit = rpt_in.valid && (idx == want);
    endfunction : hit

    // report byte index that feeds each staged field
    function automatic logic [5:0] field_index(input int unsigned fld);
        case (fld)
            `FLD_ADC:   field_index = `IDX_ADC_REF;
            `FLD_INT:   field_index = `IDX_INT_SETUP;
            `FLD_ALTER: field_index = `IDX_PIN_ALTER;
            default:    field_index = `IDX_PIN_ZERO;
        endcase
    endfunction : field_index

    // staged bytes restart at zero per report so missing bytes never load
    for (genvar g = 0; g < `FLD_COUNT; g++) begin : g_stage
        always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n)
                stage_q[g] <= 8'h00;
            else if (commit || abort)
                stage_q[g] <= 8'h00;
            else if (hit(rpt_in.index, field_index(g)))
                stage_q[g] <= rpt_in.data;
        end
    end

    assign adc_byte_q   = stage_q[`FLD_ADC];
    assign int_byte_q   = stage_q[`FLD_INT];
    assign alter_byte_q = stage_q[`FLD_ALTER];
    assign pin_byte_q   = stage_q[`FLD_PIN];

    // a last flag away from the final index is malformed and never commits
    assign last_hit = hit(rpt_in.index, 6'(RPT_BYTES - 1)) && rpt_in.last;

    // last byte cannot be a staged field, so commit one cycle after it
    logic last_q;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            last_q <= 1'b0;
        else
            last_q <= last_hit && !abort;
    end
    assign commit = last_q;

    ////////////////////////////////////////////////////////////////////////
    // adc reference
    logic [2:0] adc_ref_q;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            adc_ref_q <= `ADC_REF_RST;
        else if (commit && adc_byte_q[`BIT_LOAD])
            adc_ref_q <= adc_byte_q[`ADC_LVL_HI:`ADC_SRC];
    end
    logic [1:0] lvl;
    assign lvl            = adc_ref_q[`ADC_LVL_HI:`ADC_LVL_LO];
    assign ref_level      = runtime_settings_pkg::ref_level_t'(lvl);
    assign ref_module_on  = (lvl != 2'h0);
    assign ref_use_module = adc_ref_q[`ADC_SRC];

    ////////////////////////////////////////////////////////////////////////
    // interrupt detection
    logic pos_en_q;
    logic neg_en_q;
    logic int_mod;
    assign int_mod = commit && int_byte_q[`BIT_LOAD];

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            pos_en_q <= 1'b0;
        else if (int_mod && int_byte_q[`BIT_POS_MOD])
            pos_en_q <= int_byte_q[`BIT_POS_VAL];
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            neg_en_q <= 1'b0;
        else if (int_mod && int_byte_q[`BIT_NEG_MOD])
            neg_en_q <= int_byte_q[`BIT_NEG_VAL];
    end

    logic int_prev_q;
    logic edge_hit;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            int_prev_q <= 1'b0;
        else
            int_prev_q <= int_in;
    end
    assign edge_hit = (pos_en_q && int_in && !int_prev_q)
                   || (neg_en_q && !int_in && int_prev_q);

    // a new edge beats a clear in the same cycle
    logic flag_q;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            flag_q <= 1'b0;
        else if (edge_hit)
            flag_q <= 1'b1;
        else if (int_mod && int_byte_q[`BIT_FLAG_CLR])
            flag_q <= 1'b0;
    end
    assign detect_flag = flag_q;

    ////////////////////////////////////////////////////////////////////////
    // general pin zero
    logic [7:0] pin_cfg_q;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            pin_cfg_q <= `PIN_ZERO_RST;
        else if (commit && alter_byte_q[`BIT_LOAD])
            pin_cfg_q <= pin_byte_q;
    end

    logic gpio_mode;
    assign pin_mode  = runtime_settings_pkg::pin_des_t'(pin_cfg_q[`DES_HI:`DES_LO]);
    assign gpio_mode = (pin_mode == runtime_settings_pkg::DES_GPIO);

    // codes above 010 are don't care; the pin is left undriven for them
    logic pout_d;
    logic poe_n_d;
    always_comb begin
        pout_d  = 1'b0;
        poe_n_d = 1'b1;
        unique case (pin_mode)
            runtime_settings_pkg::DES_GPIO: begin
                poe_n_d = pin_cfg_q[`BIT_DIR];
                pout_d  = pin_cfg_q[`BIT_OUT_VAL];
            end
            runtime_settings_pkg::DES_SUSPEND: begin
                poe_n_d = 1'b0;
                pout_d  = suspend_state;
            end
            runtime_settings_pkg::DES_RX_ACT: begin
                poe_n_d = 1'b0;
                pout_d  = rx_activity;
            end
            default: begin
                poe_n_d = 1'b1;
                pout_d  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_out  <= 1'b0;
            pin_oe_n <= 1'b1;
        end else begin
            pin_out  <= pout_d;
            pin_oe_n <= poe_n_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status, mask and read port
    logic [1:0] status_q;
    logic [1:0] mask_q;
    logic [1:0] events;
    always_comb begin
        events              = 2'h0;
        events[`ST_DONE]    = commit;
        events[`ST_DETECT]  = edge_hit;
    end

    function automatic logic reg_write_to(input logic [3:0] addr);
        reg_write_to = reg_wr && (reg_addr == addr);
    endfunction : reg_write_to

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            status_q <= 2'h0;
        else if (reg_write_to(`REG_STATUS))
            status_q <= (status_q & ~reg_wdata[1:0]) | events;
        else
            status_q <= status_q | events;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            mask_q <= 2'h0;
        else if (reg_write_to(`REG_MASK))
            mask_q <= reg_wdata[1:0];
    end

    assign irq = |(status_q & mask_q);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            reg_rdata <= 8'h00;
        else if (reg_rd) begin
            unique case (reg_addr)
                `REG_STATUS:   reg_rdata <= {6'h00, status_q};
                `REG_MASK:     reg_rdata <= {6'h00, mask_q};
                `REG_SETTINGS: reg_rdata <= {flag_q, neg_en_q, pos_en_q, 2'h0, adc_ref_q};
                default:       reg_rdata <= 8'h00;
            endcase
        end else
            reg_rdata <= 8'h00;
    end

endmodule : runtime_settings_write_decoder

// ### dv/rsw_host_model.sv
// Purpose: host side that streams 64-byte command reports
// Assumes: one byte per clock, index order, changes right after a rising edge
// Notes: idle data lines carry inverted junk so a stale byte never looks valid
`timescale 1ns/1ps
module rsw_host_model (
    input  wire logic                       sys_clk,
    output runtime_settings_pkg::rpt_byte_t rpt_in,
    output logic                            abort
);
    initial begin
        rpt_in = '0;
        abort  = 1'b0;
    end
    task automatic send(input logic [7:0] b5, b6, b7, b8, input bit cut);
        for (int i = 0; i < 64; i++) begin
            @(posedge sys_clk);
            rpt_in <= '{data: i == 5 ? b5 : i == 6 ? b6 : i == 7 ? b7 : i == 8 ? b8 : 8'(i * 7),
                        index: 6'(i), valid: 1'b1, last: i == 63};
            if (cut && i == 20) begin
                abort <= 1'b1;
                break;
            end
        end
        @(posedge sys_clk);
        rpt_in.valid <= 1'b0;
        rpt_in.last  <= 1'b0;
        rpt_in.data  <= ~rpt_in.data;
        abort        <= 1'b0;
    endtask : send
endmodule : rsw_host_model

// ### dv/runtime_settings_write_decoder_sva.sv
// Purpose: port checks for the run-time settings decoder
// Assumes: one clock, asynchronous active-low reset
// Notes: settings may only move a fixed number of edges after a report ends
`timescale 1ns/1ps
module runtime_settings_write_decoder_sva (
    input wire logic                                sys_clk,
    input wire logic                                rst_n,
    input wire runtime_settings_pkg::rpt_byte_t     rpt_in,
    input wire logic                                int_in,
    input wire logic                                reg_wr,
    input wire logic                                irq,
    input wire runtime_settings_pkg::ref_level_t    ref_level,
    input wire logic                                ref_module_on,
    input wire logic                                ref_use_module,
    input wire logic                                pin_out,
    input wire logic                                pin_oe_n,
    input wire runtime_settings_pkg::pin_des_t      pin_mode,
    input wire logic                                detect_flag
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence s_commit;
        $past(rpt_in.valid && rpt_in.last, 2);
    endsequence
    chk_ref_on: assert property (
        ref_module_on == (ref_level != runtime_settings_pkg::LVL_OFF))
        else $error("reference module enable disagrees with level");
    chk_ref_hold: assert property ($changed({ref_level, ref_use_module}) |-> s_commit)
        else $error("adc reference moved without a finished report");
    chk_flag_rise: assert property (
        $rose(detect_flag) |-> $past(int_in) != $past(int_in, 2))
        else $error("detection flag set without an input edge");
    chk_flag_drop: assert property ($fell(detect_flag) |-> s_commit)
        else $error("detection flag cleared without a report");
    chk_pin_hold: assert property ($changed(pin_mode) |-> s_commit)
        else $error("pin designation moved without a report");
    chk_oe_hold: assert property (
        $changed(pin_oe_n) |-> $past(rpt_in.valid && rpt_in.last, 3))
        else $error("pin direction moved without a report");
    chk_rsvd_idle: assert property (
        pin_mode > runtime_settings_pkg::DES_RX_ACT && $stable(pin_mode)
        |-> pin_oe_n && !pin_out)
        else $error("reserved designation drives the pin");
    chk_irq_cause: assert property (
        $rose(irq) |-> $past(reg_wr) || $past(int_in) != $past(int_in, 2)
        || $past(rpt_in.valid && rpt_in.last, 2))
        else $error("interrupt rose without a cause");
endmodule : runtime_settings_write_decoder_sva
bind runtime_settings_write_decoder runtime_settings_write_decoder_sva i_chk (.sys_clk, .rst_n,
    .rpt_in, .int_in, .reg_wr, .irq, .ref_level, .ref_module_on, .ref_use_module, .pin_out,
    .pin_oe_n, .pin_mode, .detect_flag);

// ### dv/runtime_settings_write_decoder_tb.sv
// Purpose: self-checking bench for the run-time settings decoder
// Assumes: host model streams whole or aborted reports, bench keeps an integer model
// Notes: pin_out is compared in every mode, expected low for reserved codes
`timescale 1ns/1ps
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin err_total++; \
    $display("[FAIL] %s exp %0h got %0h", n, e, s); end end
module runtime_settings_write_decoder_tb;
    logic       sys_clk = 1'b0, rst_n = 1'b0, int_in = 1'b0, sus = 1'b0, rxa = 1'b0;
    logic       reg_wr = 1'b0, reg_rd = 1'b0, abort, irq, ref_module_on, ref_use_module;
    logic       pin_out, pin_oe_n, detect_flag;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata;
    logic [8:0] ops[0:10] = '{9'h199, 9'h001, 9'h181, 9'h000, 9'h006, 9'h001, 9'h000, 9'h101,
                          9'h197, 9'h001, 9'h000};
    logic [7:0] pins[0:6] = '{8'h10, 8'h00, 8'h08, 8'h19, 8'h02, 8'h07, 8'h13};
    runtime_settings_pkg::rpt_byte_t  rpt_in;
    runtime_settings_pkg::ref_level_t ref_level;
    runtime_settings_pkg::pin_des_t   pin_mode;
    int err_total = 0, check_count = 0, seed = 61, adc, pos, neg, flag, pin, sts, msk;
    rsw_host_model i_rsw_host_model (.sys_clk, .rpt_in, .abort);
    runtime_settings_write_decoder i_runtime_settings_write_decoder (.sys_clk, .rst_n, .rpt_in,
        .abort, .int_in, .suspend_state(sus), .rx_activity(rxa), .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .irq, .ref_level, .ref_module_on, .ref_use_module, .pin_out,
        .pin_oe_n, .pin_mode, .detect_flag);
    initial forever #5 sys_clk = ~sys_clk;
    ////////////////////////////////////////////////////////////////
    task automatic check_all();
        logic [2:0] m;
        m = pin[2:0];
        `CHK("ref_level", adc[2:1], ref_level)
        `CHK("ref_use", adc[0], ref_use_module)
        `CHK("ref_on", adc[2:1] != 0, ref_module_on)
        `CHK("flag", flag[0], detect_flag)
        `CHK("mode", pin[2:0], pin_mode)
        `CHK("irq", |(sts & msk), irq)
        `CHK("oe_n", pin[2:0] == 0 ? pin[3] : pin[2:0] > 2, pin_oe_n)
        `CHK("out", m == 0 ? pin[4] : m == 1 ? sus : m == 2 ? rxa : 1'b0, pin_out)
    endtask : check_all
    task automatic rpt(input logic [7:0] b5, b6, b7, b8, input bit cut);
        i_rsw_host_model.send(b5, b6, b7, b8, cut);
        if (!cut) begin
            if (b5[7]) adc = b5[2:0];
            if (b6[7] && b6[4]) pos = b6[3];
            if (b6[7] && b6[2]) neg = b6[1];
            if (b6[7] && b6[0]) flag = 0;
            if (b7[7]) pin = b8;
            sts |= 1;
        end
        repeat (3) @(posedge sys_clk);
        #1 check_all();
    endtask : rpt
    task automatic edge_in(input logic v);
        @(posedge sys_clk);
        int_in <= v;
        if (v != int_in && (v ? pos : neg)) {flag, sts} = {32'd1, sts | 2};
        repeat (3) @(posedge sys_clk);
        #1 check_all();
    endtask : edge_in
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        if (a == 4'h0) sts &= ~int'(d);
        if (a == 4'h1) msk = d & 8'h03;
        #1 check_all();
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 `CHK("rdata", e, reg_rdata)
        @(posedge sys_clk);
        #1 `CHK("rdata_idle", 8'h00, reg_rdata)
    endtask : rd
    task automatic do_reset();
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        {adc, pos, neg, flag, sts, msk, pin} = {192'd0, 32'h08};
        #1 check_all();
    endtask : do_reset
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_sim
    initial begin
        #200000;
        err_total++;
        end_sim();
    end
    initial begin
        do_reset();
        rd(4'h2, 8'h00);
        for (int i = 0; i < 8; i++)
            rpt(8'h80 | 8'(i) | (8'($random(seed)) & 8'h78), 8'h00, 8'h00, 8'h00, 1'b0);
        rpt(8'($random(seed)) & 8'h7f, 8'h00, 8'h00, 8'h00, 1'b0);
        rpt(8'h85, 8'h9f, 8'h80, 8'h10, 1'b1);
        $display("test adc reference done");
        foreach (ops[k])
            if (ops[k][8]) rpt(8'h00, ops[k][7:0], 8'h00, 8'h00, 1'b0);
            else edge_in(ops[k][0]);
        rd(4'h2, {flag[0], neg[0], pos[0], 2'b00, adc[2:0]});
        $display("test edge detection done");
        wr(4'h1, 8'h03);
        rd(4'h0, sts[7:0]);
        rd(4'h1, 8'h03);
        wr(4'h0, 8'h01);
        wr(4'h0, 8'h02);
        wr(4'h2, 8'hff);
        wr(4'hf, 8'hff);
        rd(4'hf, 8'h00);
        wr(4'h1, 8'h02);
        $display("test registers done");
        foreach (pins[k]) begin
            @(posedge sys_clk);
            sus <= 1'($random(seed));
            rxa <= 1'($random(seed));
            rpt(8'h00, 8'h00, 8'h7f, ~pins[k], 1'b0);
            rpt(8'h00, 8'h00, 8'h80, pins[k], 1'b0);
        end
        $display("test pin settings done");
        rpt(8'h87, 8'h00, 8'h00, 8'h00, 1'b0);
        do_reset();
        rd(4'h2, 8'h00);
        $display("test reset done");
        end_sim();
    end
endmodule : runtime_settings_write_decoder_tb
